/* rtl/pstc_pkg.sv */
// Shared constants and types for the transceiver status and 10Base-T control registers.
package pstc_pkg;

    // Management register addresses.
    localparam logic [4:0] REG_QUICK_POLL = 5'h11;
    localparam logic [4:0] REG_TEN_BASE = 5'h12;
    localparam logic [4:0] VENDOR_FIRST = 5'h19;
    localparam logic [4:0] VENDOR_LAST = 5'h1f;

    // Bit positions in the quick-poll detailed status word.
    localparam int QP_RATE = 15;
    localparam int QP_DUPLEX = 14;
    localparam int QP_AN_PROGRESS = 11;
    localparam int QP_SIG_LOST = 10;
    localparam int QP_PLL_ERR = 9;
    localparam int QP_FALSE_CARRIER = 8;
    localparam int QP_INVALID_SYM = 7;
    localparam int QP_HALT_SYM = 6;
    localparam int QP_PREMATURE_END = 5;
    localparam int QP_AN_DONE = 4;
    localparam int QP_NO_SIGNAL = 3;
    localparam int QP_JABBER = 2;
    localparam int QP_REMOTE_FAULT = 1;
    localparam int QP_LINK = 0;

    // Bit positions in the 10Base-T operations word.
    localparam int TB_REMOTE_JABBER = 15;
    localparam int TB_POL_REVERSED = 14;
    localparam int TB_BUS_MODE = 12;
    localparam int TB_XOVER = 11;
    localparam int TB_RX_HIZ = 10;
    localparam int TB_REG_GATE = 9;
    localparam int TB_TEST_MUX = 8;
    localparam int TB_JABBER_INH = 5;
    localparam int TB_RSVD_ONE = 4;
    localparam int TB_POL_INH = 3;
    localparam int TB_SQE_INH = 2;
    localparam int TB_LINK_INH = 1;
    localparam int TB_SQUELCH_INH = 0;

    // Reset image of the operations word before the straps are caught.
    localparam logic [15:0] TB_RESET = 16'h0010;

    // Serial management frame constants.
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [4:0] ADDR_LAST = 5'h04;
    localparam logic [4:0] DATA_LAST = 5'h0f;

    // Core cycles after reset release before the straps are trusted.
    localparam logic [2:0] STRAP_SETTLE = 3'h5;

    // Serial frame states.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_START = 7'h02,
        ST_OPCODE = 7'h04,
        ST_PHYAD = 7'h08,
        ST_REGAD = 7'h10,
        ST_TURN = 7'h20,
        ST_DATA = 7'h40
    } pstc_state_t;

    // Live conditions from the receive and link logic, all on the core clock.
    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic [2:0] an_progress;
        logic signal_lost;
        logic pll_lock_error;
        logic false_carrier;
        logic invalid_symbol;
        logic halt_symbol;
        logic premature_end;
        logic an_complete;
        logic no_signal;
        logic jabber;
        logic remote_fault;
        logic link_pass;
        logic remote_jabber;
        logic polarity_reversed;
    } pstc_phy_status_t;

    // Strap pins, sampled around reset.
    typedef struct packed {
        logic [1:0] bus_mode;
        logic [4:0] phy_addr;
        logic auto_crossover_enable;
        logic receive_output_hiz;
        logic vendor_register_gate;
    } pstc_straps_t;

    // Writable controls that steer the rest of the transceiver.
    typedef struct packed {
        logic auto_crossover_enable;
        logic receive_output_hiz;
        logic vendor_register_gate;
        logic test_mux_select;
        logic jabber_inhibit;
        logic polarity_correct_inhibit;
        logic sqe_test_inhibit;
        logic link_loss_inhibit;
        logic squelch_inhibit;
    } pstc_ten_ctrl_t;

endpackage

/* rtl/pstc_regs.sv */
// Notes on behaviour
// - Premature end of stream latches its flag.
// - Halt code group latches its flag.
// - Carrier without start delimiter latches false carrier.
// - Partner remote fault latches its flag.
// - Remote jabber latches, only at 10 Mb/s.
// - Receive tri-state bit floats receive outputs.
// - Gate bit blocks vendor registers 25 to 31.
// - Test mux select steers test path, resets zero.
// - Polarity inhibit stops automatic polarity correction.
// - SIGNAL_QUALITY_ERROR inhibit suppresses signal quality error test.
// - Link loss inhibit forces 10Base-T link pass.
// - Bus mode field reports strapped data interface.
`timescale 1ns/1ps
`default_nettype none

module pstc_regs
    import pstc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_mdc_clk,
    input wire logic i_mdio,
    input wire pstc_phy_status_t i_phy_status,
    input wire pstc_straps_t i_straps,
    output logic o_mdio,
    output logic o_mdio_oe_n,
    output pstc_ten_ctrl_t o_ten_ctrl
);

    // True for the vendor-reserved register range.
    function automatic logic is_vendor(input logic [4:0] addr);
        is_vendor = (addr >= VENDOR_FIRST) && (addr <= VENDOR_LAST);
    endfunction

    // Management clock domain state.
    pstc_state_t state_q;
    pstc_state_t state_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic [5:0] ones_q;
    logic [5:0] ones_d;
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic is_read_q;
    logic is_read_d;
    logic match_q;
    logic match_d;
    logic rd_tgl_q;
    logic rd_tgl_d;
    logic wr_tgl_q;
    logic wr_tgl_d;
    logic [4:0] rd_reg_q;
    logic [4:0] rd_reg_d;
    logic [4:0] wr_reg_q;
    logic [4:0] wr_reg_d;
    logic [15:0] wr_data_q;
    logic [15:0] wr_data_d;
    logic mdio_q;
    logic mdio_d;
    logic oe_n_q;
    logic oe_n_d;
    logic [0:0] mdc_rst_n;
    logic [1:0] op_bits;
    logic [4:0] addr_bits;

    // Core clock domain state.
    logic [9:0] straps_s;
    pstc_straps_t straps_c;
    logic [1:0] tgl_s;
    logic rd_seen_q;
    logic rd_seen_d;
    logic wr_seen_q;
    logic wr_seen_d;
    logic rd_evt;
    logic wr_evt;
    logic [2:0] strap_cnt_q;
    logic [2:0] strap_cnt_d;
    logic [4:0] phy_addr_q;
    logic [4:0] phy_addr_d;
    pstc_ten_ctrl_t ctrl_q;
    pstc_ten_ctrl_t ctrl_d;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    logic hold_drive_q;
    logic hold_drive_d;
    logic [15:0] qp_lh_q;
    logic [15:0] qp_lh_d;
    logic [15:0] tb_lh_q;
    logic [15:0] tb_lh_d;
    logic [15:0] qp_evt;
    logic [15:0] tb_evt;
    logic [15:0] qp_mask;
    logic [15:0] tb_mask;
    logic qp_clr;
    logic tb_clr;
    logic link_q;
    logic link_d;
    logic link_in;
    logic [15:0] qp_word;
    logic [15:0] tb_word;

    // Straps come from pins and the two toggles from the management clock.
    pstc_sync #(
        .WIDTH(10)
    ) u_strap_sync (
        .i_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_d(i_straps),
        .o_q(straps_s)
    );

    pstc_sync #(
        .WIDTH(2)
    ) u_tgl_sync (
        .i_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_d({rd_tgl_q, wr_tgl_q}),
        .o_q(tgl_s)
    );

    // Reset reaches the management side only while its clock runs.
    pstc_sync #(
        .WIDTH(1)
    ) u_rst_sync (
        .i_clk(i_mdc_clk),
        .i_reset_n(1'b1),
        .i_d(i_reset_n),
        .o_q(mdc_rst_n)
    );

    assign straps_c = pstc_straps_t'(straps_s);
    assign rd_evt = tgl_s[1] != rd_seen_q;
    assign wr_evt = tgl_s[0] != wr_seen_q;

    // Event sources for the latching flags of both words.
    always_comb
    begin
        qp_evt = '0;
        tb_evt = '0;
        qp_mask = '0;
        tb_mask = '0;
        qp_evt[QP_SIG_LOST] = i_phy_status.signal_lost;
        qp_evt[QP_PLL_ERR] = i_phy_status.pll_lock_error;
        qp_evt[QP_FALSE_CARRIER] = i_phy_status.false_carrier;
        qp_evt[QP_INVALID_SYM] = i_phy_status.invalid_symbol;
        qp_evt[QP_HALT_SYM] = i_phy_status.halt_symbol;
        qp_evt[QP_PREMATURE_END] = i_phy_status.premature_end;
        qp_evt[QP_JABBER] = i_phy_status.jabber & ~ctrl_q.jabber_inhibit;
        qp_evt[QP_REMOTE_FAULT] = i_phy_status.remote_fault;
        tb_evt[TB_REMOTE_JABBER] = i_phy_status.remote_jabber & ~i_phy_status.speed_100;
        tb_evt[TB_POL_REVERSED] = i_phy_status.polarity_reversed;
        qp_mask[QP_SIG_LOST] = 1'b1;
        qp_mask[QP_PLL_ERR] = 1'b1;
        qp_mask[QP_FALSE_CARRIER] = 1'b1;
        qp_mask[QP_INVALID_SYM] = 1'b1;
        qp_mask[QP_HALT_SYM] = 1'b1;
        qp_mask[QP_PREMATURE_END] = 1'b1;
        qp_mask[QP_JABBER] = 1'b1;
        qp_mask[QP_REMOTE_FAULT] = 1'b1;
        tb_mask[TB_REMOTE_JABBER] = 1'b1;
        tb_mask[TB_POL_REVERSED] = 1'b1;
    end

    // A flag set in the same cycle as its read-clear stays set, so no event is lost.
    for (genvar i = 0; i < 16; i++)
    begin : g_latch
        assign qp_lh_d[i] = qp_mask[i] & (qp_evt[i] | (qp_lh_q[i] & ~qp_clr));
        assign tb_lh_d[i] = tb_mask[i] & (tb_evt[i] | (tb_lh_q[i] & ~tb_clr));
    end

    // At 10 Mb/s the inhibit makes the link look permanently good.
    assign link_in = i_phy_status.link_pass
        | (~i_phy_status.speed_100 & ctrl_q.link_loss_inhibit);
    // Once low the link bit stays low until read; a loss during the read wins.
    assign link_d = link_in & (link_q | qp_clr);

    // Read images of the two words.
    always_comb
    begin
        qp_word = qp_lh_q;
        qp_word[QP_RATE] = i_phy_status.speed_100;
        qp_word[QP_DUPLEX] = i_phy_status.full_duplex;
        qp_word[QP_AN_PROGRESS +: 3] = i_phy_status.an_progress;
        qp_word[QP_AN_DONE] = i_phy_status.an_complete;
        qp_word[QP_NO_SIGNAL] = i_phy_status.no_signal;
        qp_word[QP_LINK] = link_q;
        tb_word = tb_lh_q;
        tb_word[TB_BUS_MODE +: 2] = straps_c.bus_mode;
        tb_word[TB_XOVER] = ctrl_q.auto_crossover_enable;
        tb_word[TB_RX_HIZ] = ctrl_q.receive_output_hiz;
        tb_word[TB_REG_GATE] = ctrl_q.vendor_register_gate;
        tb_word[TB_TEST_MUX] = ctrl_q.test_mux_select;
        tb_word[TB_JABBER_INH] = ctrl_q.jabber_inhibit;
        tb_word[TB_RSVD_ONE] = TB_RESET[TB_RSVD_ONE];
        tb_word[TB_POL_INH] = ctrl_q.polarity_correct_inhibit;
        tb_word[TB_SQE_INH] = ctrl_q.sqe_test_inhibit;
        tb_word[TB_LINK_INH] = ctrl_q.link_loss_inhibit;
        tb_word[TB_SQUELCH_INH] = ctrl_q.squelch_inhibit;
    end

    // Core side: strap capture, writes from the manager and read snapshots.
    always_comb
    begin
        rd_seen_d = tgl_s[1];
        wr_seen_d = tgl_s[0];
        strap_cnt_d = strap_cnt_q;
        phy_addr_d = phy_addr_q;
        ctrl_d = ctrl_q;
        hold_d = hold_q;
        hold_drive_d = hold_drive_q;
        qp_clr = 1'b0;
        tb_clr = 1'b0;
        // Straps are trusted only once the synchroniser has filled.
        if (strap_cnt_q != STRAP_SETTLE)
        begin
            strap_cnt_d = strap_cnt_q + 3'h1;
            if (strap_cnt_q == STRAP_SETTLE - 3'h1)
            begin
                phy_addr_d = straps_c.phy_addr;
                ctrl_d.auto_crossover_enable = straps_c.auto_crossover_enable;
                ctrl_d.receive_output_hiz = straps_c.receive_output_hiz;
                ctrl_d.vendor_register_gate = straps_c.vendor_register_gate;
            end
        end
        // Reserved and read-only positions are not stored, so stray values are dropped.
        if (wr_evt && (wr_reg_q == REG_TEN_BASE))
        begin
            ctrl_d.auto_crossover_enable = wr_data_q[TB_XOVER];
            ctrl_d.receive_output_hiz = wr_data_q[TB_RX_HIZ];
            ctrl_d.vendor_register_gate = wr_data_q[TB_REG_GATE];
            ctrl_d.test_mux_select = wr_data_q[TB_TEST_MUX];
            ctrl_d.jabber_inhibit = wr_data_q[TB_JABBER_INH];
            ctrl_d.polarity_correct_inhibit = wr_data_q[TB_POL_INH];
            ctrl_d.sqe_test_inhibit = wr_data_q[TB_SQE_INH];
            ctrl_d.link_loss_inhibit = wr_data_q[TB_LINK_INH];
            ctrl_d.squelch_inhibit = wr_data_q[TB_SQUELCH_INH];
        end
        // The snapshot is taken with the flags, and the flags clear together.
        if (rd_evt)
        begin
            hold_drive_d = ~(ctrl_q.vendor_register_gate & is_vendor(rd_reg_q));
            case (rd_reg_q)
                REG_QUICK_POLL:
                begin
                    hold_d = qp_word;
                    qp_clr = 1'b1;
                end
                REG_TEN_BASE:
                begin
                    hold_d = tb_word;
                    tb_clr = 1'b1;
                end
                default:
                begin
                    hold_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_reset_n)
        begin
            rd_seen_q <= 1'b0;
            wr_seen_q <= 1'b0;
            strap_cnt_q <= '0;
            phy_addr_q <= '0;
            ctrl_q <= '0;
            hold_q <= '0;
            hold_drive_q <= 1'b0;
            qp_lh_q <= '0;
            tb_lh_q <= '0;
            link_q <= 1'b0;
        end
        else
        begin
            rd_seen_q <= rd_seen_d;
            wr_seen_q <= wr_seen_d;
            strap_cnt_q <= strap_cnt_d;
            phy_addr_q <= phy_addr_d;
            ctrl_q <= ctrl_d;
            hold_q <= hold_d;
            hold_drive_q <= hold_drive_d;
            qp_lh_q <= qp_lh_d;
            tb_lh_q <= tb_lh_d;
            link_q <= link_d;
        end
    end

    assign op_bits = {shift_q[0], i_mdio};
    assign addr_bits = {shift_q[3:0], i_mdio};

    // Management side: frame decode on the rising management clock edge.
    // The hold word and its drive flag are published together, and the flag is read one edge after the read toggle flips,
    // which leaves the core about 64 ns to publish them; faster management clocks are not supported.
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        ones_d = ones_q;
        shift_d = shift_q;
        is_read_d = is_read_q;
        match_d = match_q;
        rd_tgl_d = rd_tgl_q;
        wr_tgl_d = wr_tgl_q;
        rd_reg_d = rd_reg_q;
        wr_reg_d = wr_reg_q;
        wr_data_d = wr_data_q;
        mdio_d = 1'b1;
        oe_n_d = 1'b1;
        case (state_q)
            ST_IDLE:
            begin
                if (i_mdio)
                begin
                    ones_d = (ones_q == PREAMBLE_BITS) ? ones_q : ones_q + 6'h01;
                end
                else
                begin
                    ones_d = '0;
                    if (ones_q == PREAMBLE_BITS)
                    begin
                        state_d = ST_START;
                    end
                end
            end
            ST_START:
            begin
                cnt_d = '0;
                state_d = i_mdio ? ST_OPCODE : ST_IDLE;
            end
            ST_OPCODE:
            begin
                shift_d = {shift_q[14:0], i_mdio};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == 5'h01)
                begin
                    cnt_d = '0;
                    is_read_d = op_bits == OP_READ;
                    state_d = (op_bits == OP_READ || op_bits == OP_WRITE) ? ST_PHYAD : ST_IDLE;
                end
            end
            ST_PHYAD:
            begin
                shift_d = {shift_q[14:0], i_mdio};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == ADDR_LAST)
                begin
                    cnt_d = '0;
                    match_d = addr_bits == phy_addr_q;
                    state_d = ST_REGAD;
                end
            end
            ST_REGAD:
            begin
                shift_d = {shift_q[14:0], i_mdio};
                cnt_d = cnt_q + 5'h01;
                if (cnt_q == ADDR_LAST)
                begin
                    cnt_d = '0;
                    state_d = ST_TURN;
                    if (is_read_q && match_q)
                    begin
                        rd_reg_d = addr_bits;
                        rd_tgl_d = ~rd_tgl_q;
                    end
                    else
                    begin
                        wr_reg_d = addr_bits;
                    end
                end
            end
            ST_TURN:
            begin
                cnt_d = cnt_q + 5'h01;
                if (is_read_q && match_q && hold_drive_q)
                begin
                    mdio_d = 1'b0;
                    oe_n_d = 1'b0;
                end
                if (cnt_q == 5'h01)
                begin
                    cnt_d = '0;
                    state_d = ST_DATA;
                    if (is_read_q && match_q && hold_drive_q)
                    begin
                        mdio_d = hold_q[15];
                        shift_d = {hold_q[14:0], 1'b0};
                    end
                end
            end
            ST_DATA:
            begin
                cnt_d = cnt_q + 5'h01;
                if (is_read_q)
                begin
                    shift_d = {shift_q[14:0], 1'b0};
                    if (match_q && hold_drive_q && (cnt_q != DATA_LAST))
                    begin
                        mdio_d = shift_q[15];
                        oe_n_d = 1'b0;
                    end
                end
                else
                begin
                    shift_d = {shift_q[14:0], i_mdio};
                end
                if (cnt_q == DATA_LAST)
                begin
                    cnt_d = '0;
                    ones_d = '0;
                    state_d = ST_IDLE;
                    if (!is_read_q && match_q)
                    begin
                        wr_data_d = {shift_q[14:0], i_mdio};
                        wr_tgl_d = ~wr_tgl_q;
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_mdc_clk)
    begin
        if (!mdc_rst_n[0])
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            ones_q <= '0;
            shift_q <= '0;
            is_read_q <= 1'b0;
            match_q <= 1'b0;
            rd_tgl_q <= 1'b0;
            wr_tgl_q <= 1'b0;
            rd_reg_q <= '0;
            wr_reg_q <= '0;
            wr_data_q <= '0;
            mdio_q <= 1'b1;
            oe_n_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ones_q <= ones_d;
            shift_q <= shift_d;
            is_read_q <= is_read_d;
            match_q <= match_d;
            rd_tgl_q <= rd_tgl_d;
            wr_tgl_q <= wr_tgl_d;
            rd_reg_q <= rd_reg_d;
            wr_reg_q <= wr_reg_d;
            wr_data_q <= wr_data_d;
            mdio_q <= mdio_d;
            oe_n_q <= oe_n_d;
        end
    end

    assign o_mdio = mdio_q;
    assign o_mdio_oe_n = oe_n_q;
    assign o_ten_ctrl = ctrl_q;

endmodule

`default_nettype wire

/* rtl/pstc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; a bit is taken once the second and third stages agree.
module pstc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;

    // A disagreeing bit keeps its old value, which filters a one-cycle glitch.
    always_comb
    begin
        out_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & out_q);
    end

    // The first stage feeds only the second.
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            out_q <= '0;
        end
        else
        begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign o_q = out_q;

endmodule

`default_nettype wire

/* testbench/pstc_regs_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

module pstc_regs_chk
    import pstc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_mdc_clk,
    input wire logic i_mdio,
    input wire pstc_phy_status_t i_phy_status,
    input wire pstc_straps_t i_straps,
    input wire logic o_mdio,
    input wire logic o_mdio_oe_n,
    input wire pstc_ten_ctrl_t o_ten_ctrl
);
    // Straps need the synchroniser fill, so they are judged six core cycles after release.
    sequence s_settled;
        $rose(i_reset_n) ##6 1'b1;
    endsequence
    // A read answer is turnaround plus sixteen bits, then the line is let go.
    sequence s_answer;
        (!o_mdio_oe_n)[*8] ##1 (!o_mdio_oe_n)[*8] ##1 !o_mdio_oe_n ##1 o_mdio_oe_n;
    endsequence

    // Strapped controls land in the operations word; test mux select and three inhibits start at zero.
    chk_xover_strap: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_settled |-> o_ten_ctrl.auto_crossover_enable == i_straps.auto_crossover_enable)
        else $error("crossover enable differs from its strap");
    chk_hiz_strap: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_settled |-> o_ten_ctrl.receive_output_hiz == i_straps.receive_output_hiz)
        else $error("receive float control differs from its strap");
    chk_gate_strap: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        s_settled |-> o_ten_ctrl.vendor_register_gate == i_straps.vendor_register_gate)
        else $error("vendor gate differs from its strap");
    chk_mux_reset: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(i_reset_n) |-> (!o_ten_ctrl.test_mux_select)[*8])
        else $error("test mux select not zero after reset");
    chk_inh_reset: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(i_reset_n) |-> (!(o_ten_ctrl.polarity_correct_inhibit
        | o_ten_ctrl.sqe_test_inhibit | o_ten_ctrl.link_loss_inhibit))[*8])
        else $error("an inhibit is set after reset");
    // Management side: the answer shape and the idle level.
    chk_turn_low: assert property (@(posedge i_mdc_clk) disable iff (!i_reset_n)
        $fell(o_mdio_oe_n) |-> !o_mdio)
        else $error("turnaround bit is not driven low");
    chk_read_len: assert property (@(posedge i_mdc_clk) disable iff (!i_reset_n)
        $fell(o_mdio_oe_n) |-> s_answer)
        else $error("read answer has the wrong length");
    chk_idle_high: assert property (@(posedge i_mdc_clk) disable iff (!i_reset_n)
        o_mdio_oe_n |-> o_mdio)
        else $error("data output not high while released");
endmodule

bind pstc_regs pstc_regs_chk u_chk (.i_core_clk, .i_reset_n, .i_mdc_clk, .i_mdio,
    .i_phy_status, .i_straps, .o_mdio, .o_mdio_oe_n, .o_ten_ctrl);

`default_nettype wire

/* testbench/pstc_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module pstc_regs_tb
    import pstc_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    pstc_phy_status_t status = '0;
    pstc_straps_t straps = '0;
    pstc_ten_ctrl_t ctrl;
    wire mdc;
    wire mdio_w;
    wire mdio_o;
    wire oe_n;
    int miscompares = 0;
    int checks_done = 0;
    int b;
    int bits[11] = '{10, 9, 8, 7, 6, 5, 2, 1, 0, 15, 14};
    logic [15:0] lfsr = 16'h0011;
    logic [15:0] ctl;
    logic [15:0] e;
    logic [17:0] base;
    logic [17:0] sh;
    logic [4:0] phy;
    logic [4:0] ra;
    logic [1:0] bm;

    always #4 i_core_clk = ~i_core_clk;

    pstc_regs dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_mdc_clk(mdc),
        .i_mdio(mdio_w), .i_phy_status(status), .i_straps(straps), .o_mdio(mdio_o),
        .o_mdio_oe_n(oe_n), .o_ten_ctrl(ctrl));
    pstc_sta_model sta (.i_mdio_out(mdio_o), .i_mdio_oe_n(oe_n), .o_mdc(mdc),
        .o_mdio(mdio_w));

    function automatic logic [15:0] next_rand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    // Expected operations word: strap mode, writable bits, reserved one.
    function automatic logic [15:0] exp12();
        return {2'b00, bm, 12'h000} | ctl & 16'h0f2f | 16'h0010;
    endfunction

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [4:0] a, input logic [4:0] pa, input logic [17:0] exp);
        sta.frame(1'b1, pa, a, 16'h0000, sh);
        check(sh, exp);
    endtask

    // Reset is held until the management side has seen enough clock edges.
    task automatic do_reset(input logic [1:0] m);
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        lfsr = next_rand(lfsr);
        bm = m;
        phy = lfsr[4:0];
        ctl = {4'h0, lfsr[7:5], 9'h000};
        straps <= {m, lfsr[4:0], lfsr[7:5]};
        repeat (10) @(posedge i_core_clk);
        sta.idle(5);
        @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        sta.idle(5);
        repeat (12) @(posedge i_core_clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Every bus mode strap, then latched flags, writes and access refusals.
    initial
    begin
        for (int m = 0; m < 4; m++)
        begin
            do_reset(m[1:0]);
            rd(REG_TEN_BASE, phy, {2'b10, exp12()});
        end
        @(posedge i_core_clk) status <= 18'h30004;
        sta.frame(1'b1, phy, REG_QUICK_POLL, 16'h0000, sh);
        for (int i = 0; i < 11; i++)
        begin
            b = bits[i];
            base = (b > 13) ? 18'h10004 : 18'h30004;
            @(posedge i_core_clk) status <= base ^ (18'h1 << ((b > 13) ? b - 14 : b + 2));
            @(posedge i_core_clk) status <= base;
            e = (b > 13) ? exp12() : 16'hc001;
            ra = (b > 13) ? REG_TEN_BASE : REG_QUICK_POLL;
            rd(ra, phy, {2'b10, e ^ (16'h1 << b)});
            rd(ra, phy, {2'b10, e});
        end
        for (int i = 0; i < 4; i++)
        begin
            lfsr = next_rand(lfsr);
            sta.frame(1'b0, phy, REG_TEN_BASE, lfsr, sh);
            sta.frame(1'b0, phy ^ 5'h01, REG_TEN_BASE, ~lfsr, sh);
            ctl = lfsr;
            rd(REG_TEN_BASE, phy, {2'b10, exp12()});
            check({9'h0, ctrl}, {9'h0, ctl[11:8], ctl[5], ctl[3:0]});
        end
        sta.frame(1'b0, phy, REG_TEN_BASE, 16'h0200, sh);
        rd(VENDOR_FIRST, phy, 18'h3ffff);
        rd(VENDOR_LAST, phy, 18'h3ffff);
        sta.frame(1'b0, phy, REG_TEN_BASE, 16'h0000, sh);
        rd(VENDOR_LAST, phy, 18'h20000);
        rd(5'h05, phy, 18'h20000);
        rd(REG_TEN_BASE, phy ^ 5'h01, 18'h3ffff);
        print_verdict();
    end

    // A hung run is cut short and counted as a mismatch.
    initial
    begin
        #600000;
        miscompares++;
        print_verdict();
    end
endmodule

`default_nettype wire

/* testbench/pstc_sta_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Station manager: owns the management clock, which stands still except during frames and idle calls.
module pstc_sta_model (
    input wire logic i_mdio_out,
    input wire logic i_mdio_oe_n,
    output logic o_mdc,
    output logic o_mdio
);
    logic drv = 1'b1;
    logic drv_en = 1'b0;

    initial o_mdc = 1'b0;
    // The line has a pull-up, so with nobody driving it reads one.
    assign o_mdio = !i_mdio_oe_n ? i_mdio_out : (drv_en ? drv : 1'b1);

    // Data changes after the fall and is captured just before the rise.
    task automatic tick(input logic b, output logic s);
        drv = b;
        #31 s = o_mdio;
        #1 o_mdc = 1'b1;
        #32 o_mdc = 1'b0;
    endtask

    task automatic idle(input int n);
        logic s;
        drv_en = 1'b0;
        repeat (n) tick(1'b1, s);
    endtask

    // A whole frame with its own preamble; sh ends with turnaround and data.
    task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [17:0] sh);
        logic [63:0] w;
        logic s;
        w = {32'hffffffff, 2'b01, rd, !rd, pa, ra, 2'b10, wd & 16'hff3f | 16'h0010};
        sh = '0;
        #3 drv_en = 1'b1;
        for (int i = 63; i >= 0; i--)
        begin
            if (rd && i == 17)
                drv_en = 1'b0;
            tick(w[i], s);
            sh = {sh[16:0], s};
        end
        drv_en = 1'b0;
    endtask
endmodule

`default_nettype wire
